/* File: hw/hspfc_pkg.sv */
// Purpose: Shared constants and types for the host serial port block.
// Assumes: One 250 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
package hspfc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 4; // Width of the decoded byte address.
  localparam logic [3:0] ADDR_CTRL = 4'h0; // Baud select, flow mode, link status.
  localparam logic [3:0] ADDR_STAT = 4'h4; // Live state of the port, read only.
  localparam logic [3:0] ADDR_TXD = 4'h8; // Character to send toward the host.
  localparam logic [3:0] ADDR_RXD = 4'hc; // Character taken from the host.

  // Control register fields and reset values.
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_SWFLOW_BIT = 3;
  localparam int CTRL_LINK_BIT = 4;
  localparam logic [2:0] CTRL_BAUD_RST = 3'h6; // 9600 baud after reset.
  localparam logic CTRL_SWFLOW_RST = 1'b0;
  localparam logic CTRL_LINK_RST = 1'b0;

  // Status register fields.
  localparam int STAT_TX_BUSY = 0;
  localparam int STAT_RX_VALID = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_RTS = 3;
  localparam int STAT_PAUSED = 4;
  localparam int STAT_TX_READY = 5;
  localparam int STAT_FRAME_ERR = 6;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Character format and timing
  // ****************************************************************
  localparam int DATA_BITS = 8;
  localparam int FRAME_BITS = 10; // Start, eight data bits, stop.
  localparam logic [7:0] CHAR_XON = 8'h11;
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam int CLK_PERIOD_NS = 4;
  localparam int OVS = 16; // Oversampling ticks per bit.
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam int BAUD_BASE = 300; // Slowest rate; others are multiples of it.
  // Clock cycles per oversampling tick at the base rate, rounded down.
  localparam int DIV_BASE = 1000000000 / (CLK_PERIOD_NS * OVS * BAUD_BASE);

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {
    HSPFC_TX_IDLE = 2'b01,
    HSPFC_TX_SEND = 2'b10
  } hspfc_tx_state_t;

  typedef enum logic [3:0] {
    HSPFC_RX_IDLE = 4'b0001,
    HSPFC_RX_START = 4'b0010,
    HSPFC_RX_DATA = 4'b0100,
    HSPFC_RX_STOP = 4'b1000
  } hspfc_rx_state_t;

  // Rate multiple of the base rate for each baud select code.
  function automatic logic [5:0] hspfc_baud_mult(input logic [2:0] sel);
    case (sel)
      3'h0: hspfc_baud_mult = 6'h01; // 300.
      3'h1: hspfc_baud_mult = 6'h02; // 600.
      3'h2: hspfc_baud_mult = 6'h04; // 1200.
      3'h3: hspfc_baud_mult = 6'h06; // 1800.
      3'h4: hspfc_baud_mult = 6'h08; // 2400.
      3'h5: hspfc_baud_mult = 6'h10; // 4800.
      default: hspfc_baud_mult = 6'h20; // 9600, also for the unused code.
    endcase
  endfunction : hspfc_baud_mult

endpackage : hspfc_pkg

/* File: hw/hspfc_rx.sv */
// Purpose: Receiver for characters the host sends on its transmit line.
// Assumes: The line is synchronous to aclk; ovs_tick runs at sixteen per bit.
// Notes: A start bit shorter than half a bit is taken as noise.
`timescale 1ns/1ns
module hspfc_rx
  import hspfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ovs_tick,
  input wire logic line,
  output logic done,
  output logic frame_err,
  output logic [7:0] data
);

  // ****************************************************************
  // Bit timing state
  // ****************************************************************
  hspfc_rx_state_t state; // Where in the frame the receiver stands.
  logic [3:0] cnt; // Oversampling ticks within the current bit.
  logic [2:0] bits; // Data bits taken so far.
  wire bit_end = ovs_tick && (cnt == OVS_LAST); // Middle of the next bit.

  // Frame walk; every sample is taken at a bit centre.
  always_ff @(posedge aclk) begin
    done <= 1'b0;
    frame_err <= 1'b0;
    if (!aresetn) begin
      state <= HSPFC_RX_IDLE;
      cnt <= 4'h0;
      bits <= 3'h0;
      data <= 8'h00;
    end else if (ovs_tick) begin
      case (state)
        HSPFC_RX_IDLE: begin
          cnt <= 4'h0;
          if (!line) begin
            state <= HSPFC_RX_START;
          end
        end
        HSPFC_RX_START: begin
          cnt <= cnt + 4'h1;
          if (cnt == OVS_MID) begin
            cnt <= 4'h0;
            bits <= 3'h0;
            state <= line ? HSPFC_RX_IDLE : HSPFC_RX_DATA;
          end
        end
        HSPFC_RX_DATA: begin
          cnt <= cnt + 4'h1;
          if (bit_end) begin
            data <= {line, data[7:1]};
            bits <= bits + 3'h1;
            if (bits == 3'h7) begin
              state <= HSPFC_RX_STOP;
            end
          end
        end
        HSPFC_RX_STOP: begin
          cnt <= cnt + 4'h1;
          if (bit_end) begin
            done <= line;
            frame_err <= !line;
            state <= HSPFC_RX_IDLE;
          end
        end
        default: begin
          state <= HSPFC_RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_rx_glitch;
    @(posedge aclk) disable iff (!aresetn)
    state == HSPFC_RX_START && ovs_tick && cnt == OVS_MID && line
      |=> state == HSPFC_RX_IDLE;
  endproperty
  a_rx_glitch: assert property (p_rx_glitch)
    else $error("Start bit high at its centre was not dropped.");

  property p_rx_stop;
    @(posedge aclk) disable iff (!aresetn)
    state == HSPFC_RX_STOP && bit_end |=> done == !frame_err && done == $past(line);
  endproperty
  a_rx_stop: assert property (p_rx_stop)
    else $error("Stop bit not judged at its centre.");

endmodule : hspfc_rx

/* File: hw/hspfc_top.sv */
// Purpose: Host serial port of a packet controller acting as the DCE end.
// Assumes: Pins are logic level, active high; AXI4-Lite software access.
// Notes: One character holding word each way; flow control paces it, and the overrun bit flags a receive loss.
`timescale 1ns/1ns
module hspfc_top
  import hspfc_pkg::*;
#(
  parameter int DIV_300 = DIV_BASE // Clock cycles per tick at 300 baud.
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic host_txd, // Serial data from the host.
  output logic host_rxd, // Serial data to the host.
  input wire logic host_rts, // Host can take data.
  output logic host_cts, // Host may send.
  output logic host_dcd, // Link connected.
  output logic host_dsr, // Device operating.
  input wire logic host_dtr // Host ready; not needed by the device.
);

  // ****************************************************************
  // Rate generator
  // ****************************************************************
  logic [2:0] baud_sel; // Selected rate code.
  logic software_flow_enable; // XON/XOFF pacing instead of RTS/CTS.
  logic link_connected; // Software reports a link on the current stream.
  logic [16:0] div_cnt; // Counts clock cycles between ticks.
  logic ovs_tick; // One pulse per sixteenth of a bit.

  // Divisor for the selected rate; the base divisor sits in a parameter
  // so that a simulation can run the port at a much higher speed.
  function automatic logic [16:0] ovs_div(input logic [2:0] sel);
    ovs_div = 17'(DIV_300 / int'(hspfc_baud_mult(sel)));
  endfunction : ovs_div

  wire [16:0] div_last = ovs_div(baud_sel) - 17'h1;

  // Free running divider; a rate change takes effect on the count in progress.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 17'h0;
      ovs_tick <= 1'b0;
    end else begin
      ovs_tick <= (div_cnt >= div_last);
      div_cnt <= (div_cnt >= div_last) ? 17'h0 : div_cnt + 17'h1;
    end
  end

  // ****************************************************************
  // Receive path and flow state
  // ****************************************************************
  logic rx_done; // A well framed character arrived.
  logic rx_ferr; // A character ended with a low stop bit.
  logic [7:0] rx_byte; // The arrived character.
  logic [7:0] rx_data; // Holding word read by software.
  logic rx_valid; // Holding word is full.
  logic overrun; // A character was lost on a full holding word.
  logic frame_err; // Sticky framing error.
  logic host_paused; // Host sent XOFF in software mode.
  logic xoff_sent; // Device has asked the host to stop.

  hspfc_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ovs_tick(ovs_tick),
    .line(host_txd),
    .done(rx_done),
    .frame_err(rx_ferr),
    .data(rx_byte)
  );

  // Flow characters from the host are consumed only in software mode.
  wire rx_is_flow = software_flow_enable && (rx_byte == CHAR_XON || rx_byte == CHAR_XOFF);
  wire rx_store = rx_done && !rx_is_flow;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  wire aw_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire wr_fire = s_axi_awready && s_axi_awvalid;
  wire ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire rd_fire = s_axi_arready && s_axi_arvalid;
  wire wr_lane0 = wr_fire && s_axi_wstrb[0];
  wire wr_ctrl = wr_lane0 && s_axi_awaddr == ADDR_CTRL;
  wire wr_txd = wr_lane0 && s_axi_awaddr == ADDR_TXD;
  wire wr_known = s_axi_awaddr == ADDR_CTRL || s_axi_awaddr == ADDR_STAT
    || s_axi_awaddr == ADDR_TXD || s_axi_awaddr == ADDR_RXD;
  wire rd_pop = rd_fire && s_axi_araddr == ADDR_RXD;
  wire rd_stat = rd_fire && s_axi_araddr == ADDR_STAT;

  hspfc_tx_state_t tx_state; // Transmitter state.
  logic tx_full; // Software character waits to be sent.
  logic [7:0] tx_hold; // That character.

  wire [31:0] ctrl_word = {27'h0, link_connected, software_flow_enable, baud_sel};
  wire [31:0] stat_word = {25'h0, frame_err, !tx_full, host_paused, host_rts,
    overrun, rx_valid, tx_state != HSPFC_TX_IDLE};
  wire rd_known = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STAT
    || s_axi_araddr == ADDR_RXD || s_axi_araddr == ADDR_TXD;
  wire [31:0] rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl_word :
    (s_axi_araddr == ADDR_STAT) ? stat_word :
    (s_axi_araddr == ADDR_RXD) ? {24'h0, rx_data} : 32'h0;

  // Write channel: both halves are taken together, then one response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= aw_take;
      s_axi_wready <= aw_take;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data is captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ar_take;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control register; only the low byte lane carries fields.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_sel <= CTRL_BAUD_RST;
      software_flow_enable <= CTRL_SWFLOW_RST;
      link_connected <= CTRL_LINK_RST;
    end else if (wr_ctrl) begin
      baud_sel <= s_axi_wdata[CTRL_BAUD_LSB +: 3];
      software_flow_enable <= s_axi_wdata[CTRL_SWFLOW_BIT];
      link_connected <= s_axi_wdata[CTRL_LINK_BIT];
    end
  end

  // Receive holding word; a new arrival wins over a pop in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      overrun <= 1'b0;
      frame_err <= 1'b0;
      host_paused <= 1'b0;
    end else begin
      if (rx_store) begin
        rx_data <= rx_byte;
        rx_valid <= 1'b1;
      end else if (rd_pop) begin
        rx_valid <= 1'b0;
      end
      if (rx_store && rx_valid && !rd_pop) begin
        overrun <= 1'b1;
      end else if (rd_pop) begin
        overrun <= 1'b0;
      end
      if (rx_ferr) begin
        frame_err <= 1'b1;
      end else if (rd_stat) begin
        frame_err <= 1'b0;
      end
      if (!software_flow_enable) begin
        host_paused <= 1'b0;
      end else if (rx_done && rx_is_flow) begin
        host_paused <= (rx_byte == CHAR_XOFF);
      end
    end
  end

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  logic [9:0] tx_shift; // Frame being sent, bit 0 on the line.
  logic [3:0] tx_ovs; // Ticks within the current bit.
  logic [3:0] tx_bit; // Bits of the frame already sent.

  // A flow character must go out even while the host has paused us,
  // otherwise both ends could wait on each other for ever.
  wire need_xoff = software_flow_enable && rx_valid && !xoff_sent;
  wire need_xon = software_flow_enable && !rx_valid && xoff_sent;
  wire flow_pending = need_xoff || need_xon;
  wire host_ready = software_flow_enable ? !host_paused : host_rts;
  wire tx_start = tx_state == HSPFC_TX_IDLE && (flow_pending || (tx_full && host_ready));
  wire [7:0] tx_char = flow_pending ? (need_xoff ? CHAR_XOFF : CHAR_XON) : tx_hold;
  wire tx_bit_end = ovs_tick && tx_ovs == OVS_LAST;

  // Holding word for software; writes to a full word are dropped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_full <= 1'b0;
      tx_hold <= 8'h00;
      xoff_sent <= 1'b0;
    end else begin
      if (wr_txd && !tx_full) begin
        tx_hold <= s_axi_wdata[7:0];
        tx_full <= 1'b1;
      end else if (tx_start && !flow_pending) begin
        tx_full <= 1'b0;
      end
      if (!software_flow_enable) begin
        xoff_sent <= 1'b0;
      end else if (tx_start && flow_pending) begin
        xoff_sent <= need_xoff;
      end
    end
  end

  // Frame shifter; a started character always completes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= HSPFC_TX_IDLE;
      tx_shift <= 10'h3ff;
      tx_ovs <= 4'h0;
      tx_bit <= 4'h0;
    end else begin
      case (tx_state)
        HSPFC_TX_IDLE: begin
          if (tx_start) begin
            tx_shift <= {1'b1, tx_char, 1'b0};
            tx_ovs <= 4'h0;
            tx_bit <= 4'h0;
            tx_state <= HSPFC_TX_SEND;
          end
        end
        HSPFC_TX_SEND: begin
          if (ovs_tick) begin
            tx_ovs <= tx_ovs + 4'h1;
          end
          if (tx_bit_end) begin
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'(FRAME_BITS - 1)) begin
              tx_state <= HSPFC_TX_IDLE;
            end
          end
        end
        default: begin
          tx_state <= HSPFC_TX_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Host pins
  // ****************************************************************
  // In hardware flow mode CTS follows the holding word one cycle late, so a host that reacts
  // slowly can still overrun it; the overrun bit reports that case.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_rxd <= 1'b1;
      host_cts <= 1'b1;
      host_dcd <= 1'b0;
      host_dsr <= 1'b1;
    end else begin
      host_rxd <= (tx_state == HSPFC_TX_SEND) ? tx_shift[0] : 1'b1;
      host_cts <= software_flow_enable ? 1'b1 : !rx_valid;
      host_dcd <= link_connected;
      host_dsr <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_start_gate;
    @(posedge aclk) disable iff (!aresetn)
    tx_start && !software_flow_enable |-> host_rts;
  endproperty
  a_start_gate: assert property (p_start_gate)
    else $error("Character started while RTS was off.");

  property p_start_bit;
    @(posedge aclk) disable iff (!aresetn)
    $rose(tx_state == HSPFC_TX_SEND) |=> !host_rxd;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("Frame did not open with a low start bit.");

  property p_idle_high;
    @(posedge aclk) disable iff (!aresetn)
    tx_state == HSPFC_TX_IDLE ##1 tx_state == HSPFC_TX_IDLE |-> host_rxd;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("Line not high while idle.");

  property p_cts;
    @(posedge aclk) disable iff (!aresetn)
    !software_flow_enable ##1 !software_flow_enable |-> host_cts == !$past(rx_valid);
  endproperty
  a_cts: assert property (p_cts)
    else $error("CTS does not follow the holding word.");

  property p_dcd;
    @(posedge aclk) disable iff (!aresetn)
    $changed(link_connected) |=> host_dcd == $past(link_connected);
  endproperty
  a_dcd: assert property (p_dcd)
    else $error("DCD does not track the link status.");

  property p_dsr;
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> host_dsr;
  endproperty
  a_dsr: assert property (p_dsr)
    else $error("DSR dropped.");

  property p_xoff;
    @(posedge aclk) disable iff (!aresetn)
    tx_start && need_xoff |=> tx_shift[8:1] == CHAR_XOFF && xoff_sent;
  endproperty
  a_xoff: assert property (p_xoff)
    else $error("XOFF not sent for a full holding word.");

  property p_rx_keep;
    @(posedge aclk) disable iff (!aresetn)
    rx_done && !software_flow_enable |=> rx_valid && rx_data == $past(rx_byte);
  endproperty
  a_rx_keep: assert property (p_rx_keep)
    else $error("Received character was not kept.");

  property p_frame_len;
    @(posedge aclk) disable iff (!aresetn)
    tx_state == HSPFC_TX_SEND && tx_bit_end && tx_bit == 4'h9 |=> tx_state == HSPFC_TX_IDLE;
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("Frame length is not ten bits.");

endmodule : hspfc_top

/* File: tb/hspfc_host_model.sv */
// Purpose: Behavioural host terminal on the far side of the serial port.
// Assumes: The bench sets bit_cyc to the clock cycles of one bit at the chosen rate.
// Notes: Frames are checked by sampling each bit at its centre.
`timescale 1ns/1ns
module hspfc_host_model (
  input wire logic aclk,
  input wire logic rxd,
  input wire logic cts,
  input wire logic hold_full,
  input wire logic [15:0] bit_cyc,
  output logic txd,
  output logic rts,
  output logic [7:0] rx_byte,
  output logic rx_stop,
  output int rx_cnt
);
  // ****************************************************************
  // Flow control and receiver
  // ****************************************************************
  // The host drops its ready line whenever its own buffer is full.
  assign rts = !hold_full;
  initial begin
    txd = 1'b1;
    rx_cnt = 0;
    rx_byte = 8'h00;
    rx_stop = 1'b0;
  end
  // Each start edge is followed to mid bit, then data bits LSB first and the stop bit.
  always begin : rx_proc
    logic [7:0] b;
    @(negedge rxd);
    repeat (bit_cyc / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge aclk);
      b[i] = rxd;
    end
    repeat (bit_cyc) @(posedge aclk);
    rx_stop = rxd;
    rx_byte = b;
    rx_cnt++;
  end
  // Sends one character; waits for CTS, which keeps the device from overrun in hardware flow mode only.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    wait (cts === 1'b1);
    for (int i = 0; i < 10; i++) begin
      @(posedge aclk);
      txd <= f[i];
      repeat (bit_cyc - 1) @(posedge aclk);
    end
  endtask : send
  // Pulls the line low for a few cycles only, as noise on the wire would.
  task automatic glitch(input int cyc);
    @(posedge aclk);
    txd <= 1'b0;
    repeat (cyc) @(posedge aclk);
    txd <= 1'b1;
  endtask : glitch
endmodule : hspfc_host_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the host serial port.
// Assumes: A short rate divider keeps even the slowest rate quick to simulate.
// Notes: Every rate is crossed in both directions, then flow control is stressed.
`timescale 1ns/1ns
module tb_top
  import hspfc_pkg::*;
;
  localparam int DIV = 96; // Shortened divider; 9600 baud gets three cycles a tick.
  typedef struct packed { logic [2:0] sel; logic [7:0] dev; logic [7:0] host; } hspfc_row_t;
  hspfc_row_t rows [7] = '{'{3'h6, 8'h55, 8'ha3}, '{3'h0, 8'h01, 8'h80}, '{3'h1, 8'hfe, 8'h7f},
    '{3'h2, 8'h3c, 8'hc3}, '{3'h3, 8'h00, 8'hff}, '{3'h4, 8'h96, 8'h69}, '{3'h5, 8'h11, 8'h13}};
  int mult [7] = '{1, 2, 4, 6, 8, 16, 32};
  logic aclk = 1'b0, aresetn = 1'b0, host_dtr = 1'b0, hold_full = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, host_txd, host_rxd, host_rts;
  logic host_cts, host_dcd, host_dsr, rx_stop;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [7:0] rx_byte;
  logic [15:0] bit_cyc = 16'h30;
  int rx_cnt, miscompares = 0, tests_run = 0, n0;
  always #2 aclk = !aclk;
  hspfc_top #(.DIV_300(DIV)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .host_txd, .host_rxd, .host_rts, .host_cts, .host_dcd,
    .host_dsr, .host_dtr);
  hspfc_host_model i_host (.aclk, .rxd(host_rxd), .cts(host_cts), .hold_full, .bit_cyc,
    .txd(host_txd), .rts(host_rts), .rx_byte, .rx_stop, .rx_cnt);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  // One AXI4-Lite transfer; each channel is released at the edge that takes it.
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1) && n < 200);
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk("bus answer", 32'h1, {31'h0, n < 200});
  endtask : axi
  // Waits, bounded, for the host to finish one more character.
  task automatic wait_rx(input int old);
    for (int i = 0; i < 20 * bit_cyc && rx_cnt == old; i++) @(posedge aclk);
  endtask : wait_rx
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (90000) @(posedge aclk);
    miscompares++;
    test_done();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset pins", 4'b1101, {host_rxd, host_cts, host_dcd, host_dsr});
    axi(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h6, rd);
    $display("Test reset done");
    foreach (rows[k]) begin
      bit_cyc <= 16'(DIV / mult[rows[k].sel] * 16);
      axi(1'b1, ADDR_CTRL, {29'h0, rows[k].sel});
      n0 = rx_cnt;
      axi(1'b1, ADDR_TXD, {24'h0, rows[k].dev});
      wait_rx(n0);
      chk("host got", {23'h0, rows[k].dev, 1'b1}, {23'h0, rx_byte, rx_stop});
      i_host.send(rows[k].host);
      repeat (4) @(posedge aclk);
      chk("cts full", 32'h0, {31'h0, host_cts});
      axi(1'b0, ADDR_RXD, 32'h0);
      chk("rx data", {24'h0, rows[k].host}, rd);
      repeat (2) @(posedge aclk);
      chk("cts free", 32'h1, {31'h0, host_cts});
      $display("Test rate %0d done", rows[k].sel);
    end
    hold_full <= 1'b1;
    n0 = rx_cnt;
    axi(1'b1, ADDR_TXD, 32'ha5);
    for (int i = 0; i < 3 * bit_cyc; i++) @(posedge aclk) if (host_rxd !== 1'b1) n0 = -1;
    chk("held by rts", n0, rx_cnt);
    hold_full <= 1'b0;
    wait_rx(n0);
    chk("after rts", 32'ha5, {24'h0, rx_byte});
    $display("Test hardware flow done");
    host_dtr <= 1'b1;
    axi(1'b1, ADDR_CTRL, 32'h16);
    @(posedge aclk);
    chk("dcd dsr", 2'b11, {host_dcd, host_dsr});
    axi(1'b0, 4'h2, 32'h0);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("unmapped data", 32'h0, rd);
    $display("Test status lines done");
    axi(1'b1, ADDR_CTRL, 32'hd);
    n0 = rx_cnt;
    i_host.send(8'h42);
    wait_rx(n0);
    chk("xoff sent", {CHAR_XOFF, 1'b1}, {rx_byte, host_cts});
    n0 = rx_cnt;
    axi(1'b0, ADDR_RXD, 32'h0);
    wait_rx(n0);
    chk("xon sent", {24'h42, CHAR_XON}, {rd[23:0], rx_byte});
    i_host.send(CHAR_XOFF);
    n0 = rx_cnt;
    axi(1'b1, ADDR_TXD, 32'h5a);
    repeat (3 * bit_cyc) @(posedge aclk);
    chk("paused", n0, rx_cnt);
    i_host.send(CHAR_XON);
    wait_rx(n0);
    chk("resumed", 32'h5a, {24'h0, rx_byte});
    $display("Test software flow done");
    i_host.glitch(bit_cyc / 4);
    repeat (12 * bit_cyc) @(posedge aclk);
    axi(1'b0, ADDR_STAT, 32'h0);
    chk("glitch", 32'h0, {30'h0, rd[STAT_FRAME_ERR], rd[STAT_RX_VALID]});
    $display("Test glitch done");
    test_done();
  end
endmodule : tb_top
